// *** hdl/vim_regs.vh ***
// Purpose: Constants for the vectored interrupt mapping block.
// Assumes: Included by bare name from the design files.
// Notes: Line numbers, widths and reset values only; no logic here.
`ifndef VIM_REGS_VH
`define VIM_REGS_VH
// Line counts per core
`define VIM_MAIN_LINES 41
`define VIM_SEC_LINES 32
// Priority field widths and values per field group
`define VIM_PRIO_W 3
`define VIM_MAIN_LEVELS 8
`define VIM_SEC_LEVELS 4
`define VIM_PRIO_PER_WORD 4
// Vector number width and idle code
`define VIM_VEC_W 6
`define VIM_VEC_NONE 6'h3f
// Enable word split
`define VIM_EN_LOW_W 32
`define VIM_EN_HIGH_W 9
// Line assignments
`define VIM_LN_WDT 0
`define VIM_LN_BROWNOUT 1
`define VIM_LN_RSV2 2
`define VIM_LN_DMA 3
`define VIM_LN_GRP0 4
`define VIM_LN_PIN0 5
`define VIM_LN_MTICK 9
`define VIM_LN_MRATE 10
`define VIM_LN_CTMR0 11
`define VIM_LN_SCTMR 16
`define VIM_LN_SER0 17
`define VIM_LN_CONV_A 26
`define VIM_LN_CONV_B 27
`define VIM_LN_CONV_T 28
`define VIM_LN_CLOCK 29
`define VIM_LN_RSV30 30
`define VIM_LN_MBOX 31
`define VIM_LN_GRP1 32
`define VIM_LN_PIN4 33
`define VIM_LN_RSV37 37
`define VIM_LN_RPT 40
// Reset values
`define VIM_VBASE_RST 32'h0000_0000
`define VIM_VBASE_ALIGN 7
`define VIM_FETCH_RST 32'h0000_0000
`define VIM_HELD_RST 3'h7
// Table slots taken by system exceptions ahead of line 0
`define VIM_VEC_OFS 6'h10
`endif

// *** hdl/vim_arbiter.v ***
// Purpose: Priority arbiter over pending, enabled request lines.
// Assumes: Lower priority field value means more urgent.
// Notes: Ties go to the lower line number only as a tie break.
`timescale 1ns/1ps
`default_nettype none
`include "vim_regs.vh"
module vim_arbiter #(
   parameter N = 32
) (
   // Requests and priorities
   input wire [N-1:0] req,
   input wire [N*`VIM_PRIO_W-1:0] prio,
   // Winner
   output reg found,
   output reg [`VIM_VEC_W-1:0] win_vec,
   output reg [`VIM_PRIO_W-1:0] win_prio
);
   integer i;
   // Scan from the top so equal levels settle on the lower line
   always @* begin
      found = 1'b0;
      win_vec = `VIM_VEC_NONE;
      win_prio = {`VIM_PRIO_W{1'b1}};
      for (i = N - 1; i >= 0; i = i - 1) begin
         if (req[i] && (!found || prio[i*`VIM_PRIO_W +: `VIM_PRIO_W] <= win_prio)) begin
            found = 1'b1;
            win_vec = i[`VIM_VEC_W-1:0];
            win_prio = prio[i*`VIM_PRIO_W +: `VIM_PRIO_W];
         end
      end
   end
endmodule // vim_arbiter
`default_nettype wire

// *** hdl/vim_top.v ***
// Purpose: Vectored interrupt mapping for the main and secondary cores.
// Assumes: Sources synchronous to core_clk; config ports held static by the system.
// Notes: Control bits are plain ports since no software bus reaches this block.
//        Both cores share one source map; enables, levels and vector bases are kept per core.
//        Secondary levels keep the top two bits of each field.
`timescale 1ns/1ps
`default_nettype none
`include "vim_regs.vh"
// How it works
// - Main core: eight levels, requests not above execution priority are masked.
// - Secondary core: four levels, with the same hardware masking.
// - Secondary core only sees lines 0 to 31.
// - Lines 32 to 40 reach only the main core.
// - Winner chosen by programmed level, not by line number.
// - Each line is the OR of all its peripheral's flags.
// - One selected line can also drive the non-maskable input.
// - Per-core vector base offset relocates the handler fetch address.
// - Higher request during entry is taken as a late arrival.
// - Line 0 watchdog warning, line 1 brownout, line 3 DMA A, B, error.
// - Lines 5 to 8 pin or pattern slice n, line 4 group zero.
// - Line 10 is OR of four multi-rate flags, line 9 micro tick.
// - Lines 11 to 15 counter timers, line 16 state timer events.
// - Lines 26 to 28 converter A, B, threshold; 17 to 25 serial.
// - Line 29 clock alarm and wake, line 31 mailbox.
// - Line 40 repetitive timer masked compare flag.
// - Priority words hold four 3-bit fields for consecutive lines.
// - Low set-enable word covers lines 0 to 31, high word the rest.
module vim_top (
   // Clock and reset
   input wire core_clk,
   input wire rst_n,
   // Peripheral flag sources
   input wire watchdog_warning_flag,
   input wire brownout_detector,
   input wire [2:0] dma_flags,
   input wire gpio_group_zero_irq,
   input wire [3:0] pin_irq_zero,
   input wire micro_tick_timer,
   input wire [3:0] multi_rate_channel_flag,
   input wire [9:0] general_counter_timer,
   input wire state_config_timer,
   input wire [8:0] serial_irq,
   input wire converter_sequence_a_done,
   input wire converter_sequence_b_done,
   input wire converter_threshold_irq,
   input wire [1:0] clock_alarm_wake,
   input wire mailbox_irq,
   input wire gpio_group_one_irq,
   input wire [3:0] pin_irq_high,
   input wire repetitive_compare_flag,
   // Main core configuration
   input wire [`VIM_EN_LOW_W-1:0] main_set_enable_low,
   input wire [`VIM_EN_HIGH_W-1:0] main_set_enable_high,
   input wire [`VIM_EN_LOW_W-1:0] main_clr_enable_low,
   input wire [`VIM_EN_HIGH_W-1:0] main_clr_enable_high,
   input wire [44*`VIM_PRIO_W-1:0] main_prio_words,
   input wire main_vbase_we,
   input wire [31:0] main_vbase_wdata,
   // Secondary core configuration
   input wire [`VIM_EN_LOW_W-1:0] sec_set_enable,
   input wire [`VIM_EN_LOW_W-1:0] sec_clr_enable,
   input wire [`VIM_SEC_LINES*`VIM_PRIO_W-1:0] sec_prio_words,
   input wire sec_vbase_we,
   input wire [31:0] sec_vbase_wdata,
   // Non-maskable routing
   input wire nmi_route_en,
   input wire [`VIM_VEC_W-1:0] nmi_route_sel,
   // Main core handshake
   input wire [`VIM_PRIO_W-1:0] main_exec_prio,
   input wire main_entry_busy,
   input wire main_take,
   // Secondary core handshake
   input wire [1:0] sec_exec_prio,
   input wire sec_entry_busy,
   input wire sec_take,
   // Main core outputs
   output wire main_irq_req,
   output reg [`VIM_VEC_W-1:0] main_vec_q,
   output reg [31:0] main_fetch_addr_q,
   output reg main_late_q,
   output reg [`VIM_EN_LOW_W-1:0] main_enable_low_q,
   output reg [`VIM_EN_HIGH_W-1:0] main_enable_high_q,
   output wire main_nmi,
   // Secondary core outputs
   output wire sec_irq_req,
   output reg [`VIM_VEC_W-1:0] sec_vec_q,
   output reg [31:0] sec_fetch_addr_q,
   output reg sec_late_q,
   output reg [`VIM_EN_LOW_W-1:0] sec_enable_q,
   output wire sec_nmi
);
   ////////////////////////////////////////////////////////////////////////////
   // Source to line mapping
   wire [`VIM_MAIN_LINES-1:0] line_w;
   // A line stays pending while any of its flags is high
   assign line_w[`VIM_LN_WDT] = watchdog_warning_flag;
   assign line_w[`VIM_LN_BROWNOUT] = brownout_detector;
   assign line_w[`VIM_LN_RSV2] = 1'b0;
   assign line_w[`VIM_LN_DMA] = |dma_flags;
   // GPIO group and pin lines
   assign line_w[`VIM_LN_GRP0] = gpio_group_zero_irq;
   assign line_w[`VIM_LN_PIN0 +: 4] = pin_irq_zero;
   // Timer lines
   assign line_w[`VIM_LN_MTICK] = micro_tick_timer;
   assign line_w[`VIM_LN_MRATE] = |multi_rate_channel_flag;
   // Match and capture of each counter timer pair into one line
   genvar g;
   generate
      for (g = 0; g < 5; g = g + 1) begin : g_ctmr
         assign line_w[`VIM_LN_CTMR0 + g] = |general_counter_timer[2*g +: 2];
      end
   endgenerate
   assign line_w[`VIM_LN_SCTMR] = state_config_timer;
   // Serial, converter, clock and mailbox lines
   assign line_w[`VIM_LN_SER0 +: 9] = serial_irq;
   assign line_w[`VIM_LN_CONV_A] = converter_sequence_a_done;
   assign line_w[`VIM_LN_CONV_B] = converter_sequence_b_done;
   assign line_w[`VIM_LN_CONV_T] = converter_threshold_irq;
   assign line_w[`VIM_LN_CLOCK] = |clock_alarm_wake;
   assign line_w[`VIM_LN_RSV30] = 1'b0;
   assign line_w[`VIM_LN_MBOX] = mailbox_irq;
   // Lines above 31 exist on the main core only
   assign line_w[`VIM_LN_GRP1] = gpio_group_one_irq;
   assign line_w[`VIM_LN_PIN4 +: 4] = pin_irq_high;
   assign line_w[`VIM_LN_RSV37 +: 3] = 3'h0;
   assign line_w[`VIM_LN_RPT] = repetitive_compare_flag;

   ////////////////////////////////////////////////////////////////////////////
   // Enable bits, set wins over clear in the same cycle
   // Set and clear are per-cycle levels, one cycle per action
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         main_enable_low_q <= 32'h0000_0000;
         main_enable_high_q <= 9'h000;
         sec_enable_q <= 32'h0000_0000;
      end else begin
         main_enable_low_q <= (main_enable_low_q & ~main_clr_enable_low) |
            main_set_enable_low;
         main_enable_high_q <= (main_enable_high_q & ~main_clr_enable_high) |
            main_set_enable_high;
         // No high word: the secondary core never sees lines above 31
         sec_enable_q <= (sec_enable_q & ~sec_clr_enable) | sec_set_enable;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Vector base offsets, low bits forced to table alignment
   // A write lands next cycle; a take in that cycle uses the old base
   reg [31:0] main_vbase_q;
   reg [31:0] sec_vbase_q;
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         main_vbase_q <= `VIM_VBASE_RST;
         sec_vbase_q <= `VIM_VBASE_RST;
      end else begin
         if (main_vbase_we) begin
            main_vbase_q <= {main_vbase_wdata[31:`VIM_VBASE_ALIGN],
               {`VIM_VBASE_ALIGN{1'b0}}};
         end
         if (sec_vbase_we) begin
            sec_vbase_q <= {sec_vbase_wdata[31:`VIM_VBASE_ALIGN],
               {`VIM_VBASE_ALIGN{1'b0}}};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Priority fields; secondary keeps only its top two bits of level
   wire [`VIM_MAIN_LINES*`VIM_PRIO_W-1:0] main_prio_w;
   wire [`VIM_SEC_LINES*`VIM_PRIO_W-1:0] sec_prio_w;
   // Four fields per word, unused tail fields of the last word ignored
   assign main_prio_w = main_prio_words[`VIM_MAIN_LINES*`VIM_PRIO_W-1:0];
   // Secondary fields drop their low bit, leaving four levels
   generate
      for (g = 0; g < `VIM_SEC_LINES; g = g + 1) begin : g_sprio
         assign sec_prio_w[g*3 +: 3] = {sec_prio_words[g*3+1 +: 2], 1'b0};
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Pending candidates
   wire [`VIM_MAIN_LINES-1:0] main_cand_w;
   wire [`VIM_SEC_LINES-1:0] sec_cand_w;
   // Main core sees every line; high enable word above the low one
   assign main_cand_w = line_w & {main_enable_high_q, main_enable_low_q};
   // Only the low 32 lines are wired to the secondary core
   assign sec_cand_w = line_w[`VIM_SEC_LINES-1:0] & sec_enable_q;

   // Winner of each core's arbitration
   wire main_found;
   wire [`VIM_VEC_W-1:0] main_win_vec;
   wire [`VIM_PRIO_W-1:0] main_win_prio;
   wire sec_found;
   wire [`VIM_VEC_W-1:0] sec_win_vec;
   wire [`VIM_PRIO_W-1:0] sec_win_prio;

   // Level-only arbitration for each core
   // Equal levels fall to the lower line, as a tie break only
   vim_arbiter #(.N(`VIM_MAIN_LINES)) u_main_arb (
      .req(main_cand_w),
      .prio(main_prio_w),
      .found(main_found),
      .win_vec(main_win_vec),
      .win_prio(main_win_prio)
   );
   vim_arbiter #(.N(`VIM_SEC_LINES)) u_sec_arb (
      .req(sec_cand_w),
      .prio(sec_prio_w),
      .found(sec_found),
      .win_vec(sec_win_vec),
      .win_prio(sec_win_prio)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Hardware level masking: must be strictly more urgent than execution
   wire main_pass_w;
   wire sec_pass_w;
   wire [2:0] sec_exec_w;
   // Secondary execution level widened with a zero low bit
   assign sec_exec_w = {sec_exec_prio, 1'b0};
   // Level zero masks everything, since no level lies below it
   assign main_pass_w = main_found && (main_win_prio < main_exec_prio);
   assign sec_pass_w = sec_found && (sec_win_prio < sec_exec_w);
   assign main_irq_req = main_pass_w;
   assign sec_irq_req = sec_pass_w;

   ////////////////////////////////////////////////////////////////////////////
   // Vector latch per core. During entry a more urgent winner replaces the
   // held vector without a new entry, so the core fetches the late one.
   // The held level stays after entry; the next take overwrites it.
   reg [`VIM_PRIO_W-1:0] main_held_prio_q;
   reg [`VIM_PRIO_W-1:0] sec_held_prio_q;
   // Slot address and late test of each core
   wire [31:0] main_slot_w;
   wire [31:0] sec_slot_w;
   wire main_late_w;
   wire sec_late_w;
   // Handler slot: base plus one word per entry, after the exception slots
   assign main_slot_w = main_vbase_q + {24'h000000, main_win_vec + `VIM_VEC_OFS, 2'h0};
   assign sec_slot_w = sec_vbase_q + {24'h000000, sec_win_vec + `VIM_VEC_OFS, 2'h0};
   // A late arrival must beat the level already held, not only pass masking
   assign main_late_w = main_entry_busy && main_pass_w && (main_win_prio < main_held_prio_q);
   assign sec_late_w = sec_entry_busy && sec_pass_w && (sec_win_prio < sec_held_prio_q);

   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         main_vec_q <= `VIM_VEC_NONE;
         main_held_prio_q <= `VIM_HELD_RST;
         main_late_q <= 1'b0;
         main_fetch_addr_q <= `VIM_FETCH_RST;
      end else begin
         main_late_q <= 1'b0;
         if (main_take && main_pass_w) begin
            // Normal entry: latch the winner and its level
            main_vec_q <= main_win_vec;
            main_held_prio_q <= main_win_prio;
            main_fetch_addr_q <= main_slot_w;
         end else if (main_late_w) begin
            // Late arrival: swap the vector, no second entry
            main_vec_q <= main_win_vec;
            main_held_prio_q <= main_win_prio;
            main_late_q <= 1'b1;
            main_fetch_addr_q <= main_slot_w;
         end
      end
   end

   // Same scheme for the secondary core
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sec_vec_q <= `VIM_VEC_NONE;
         sec_held_prio_q <= `VIM_HELD_RST;
         sec_late_q <= 1'b0;
         sec_fetch_addr_q <= `VIM_FETCH_RST;
      end else begin
         sec_late_q <= 1'b0;
         if (sec_take && sec_pass_w) begin
            // Normal entry: latch the winner and its level
            sec_vec_q <= sec_win_vec;
            sec_held_prio_q <= sec_win_prio;
            sec_fetch_addr_q <= sec_slot_w;
         end else if (sec_late_w) begin
            // Late arrival: swap the vector, no second entry
            sec_vec_q <= sec_win_vec;
            sec_held_prio_q <= sec_win_prio;
            sec_late_q <= 1'b1;
            sec_fetch_addr_q <= sec_slot_w;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Non-maskable routing; a high line can only reach the main core
   wire nmi_line_w;
   assign nmi_line_w = (nmi_route_sel < `VIM_MAIN_LINES) ? line_w[nmi_route_sel] : 1'b0;
   // Guarded index: a selection past line 40 reads quiet
   assign main_nmi = nmi_route_en && nmi_line_w;
   // Secondary output only for the lines it owns
   assign sec_nmi = nmi_route_en && (nmi_route_sel < `VIM_SEC_LINES) && nmi_line_w;
endmodule // vim_top
`default_nettype wire

// *** sim/vim_core_model.sv ***
// Purpose: Behavioural core that accepts vectored requests from the controller.
// Assumes: One clock; take is sampled by the controller together with its request.
// Notes: lag picks a prompt or a slow core; entry lasts one to four cycles, set by lag.
`timescale 1ns/1ps
`default_nettype none
module vim_core_model (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Controller handshake
   input wire logic irq_req,
   input wire logic [1:0] lag,
   output logic take,
   output logic entry_busy
);
   logic [1:0] st_q;
   logic [1:0] cnt_q;
   // Idle, take, entry, then wait until the handler clears its source
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= 2'd0;
         cnt_q <= 2'd0;
      end else begin
         cnt_q <= cnt_q + 2'd1;
         case (st_q)
            2'd0: begin
               if (!irq_req) cnt_q <= 2'd0;
               else if (cnt_q >= lag) st_q <= 2'd1;
            end
            2'd1: st_q <= 2'd2;
            2'd2: if (cnt_q == 2'd3) st_q <= 2'd3;
            default: begin
               // No retake of a line still held high by its source
               if (!irq_req) st_q <= 2'd0;
               cnt_q <= 2'd0;
            end
         endcase
      end
   end
   assign take = (st_q == 2'd1);
   assign entry_busy = (st_q == 2'd2);
endmodule // vim_core_model
`default_nettype wire

// *** sim/vim_sva.sv ***
// Purpose: Port checker for the vectored interrupt mapping block.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes: Bound to vim_top below.
`timescale 1ns/1ps
`default_nettype none
module vim_sva (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Observed ports
   input wire logic [2:0] main_exec_prio,
   input wire logic [1:0] sec_exec_prio,
   input wire logic main_irq_req,
   input wire logic sec_irq_req,
   input wire logic [31:0] main_set_enable_low,
   input wire logic [31:0] main_clr_enable_low,
   input wire logic [31:0] main_enable_low_q,
   input wire logic main_take,
   input wire logic main_vbase_we,
   input wire logic [31:0] main_vbase_wdata,
   input wire logic [5:0] main_vec_q,
   input wire logic [31:0] main_fetch_addr_q,
   input wire logic main_late_q,
   input wire logic [5:0] nmi_route_sel,
   input wire logic sec_nmi
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   logic [31:0] vb_q;
   // Shadow of the stored base, low seven bits dropped for alignment
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) vb_q <= 32'h0000_0000;
      else if (main_vbase_we) vb_q <= {main_vbase_wdata[31:7], 7'h00};
   end
   ////////////////////////////////////////////////////////////////
   chk_main_mask: assert property (main_exec_prio == 3'h0 |-> !main_irq_req)
      else $error("main request passed at priority zero");
   chk_sec_mask: assert property (sec_exec_prio == 2'h0 |-> !sec_irq_req)
      else $error("secondary request passed at priority zero");
   chk_enable_set: assert property (main_set_enable_low != 32'h0 |=>
      (main_enable_low_q & $past(main_set_enable_low)) == $past(main_set_enable_low))
      else $error("set enable not taken");
   chk_enable_clear: assert property (main_clr_enable_low != 32'h0 &&
      main_set_enable_low == 32'h0 |=> (main_enable_low_q & $past(main_clr_enable_low)) == 32'h0)
      else $error("clear enable not taken");
   chk_fetch_addr: assert property (main_take && main_irq_req && !main_vbase_we |=>
      main_fetch_addr_q == vb_q + ((32'(main_vec_q) + 32'd16) << 2))
      else $error("fetch address not base plus vector slot");
   chk_late_pulse: assert property (main_late_q |=> !main_late_q)
      else $error("late flag longer than one cycle");
   chk_late_replace: assert property (main_late_q |-> main_vec_q != $past(main_vec_q))
      else $error("late flag without a new vector");
   chk_sec_nmi_range: assert property (nmi_route_sel >= 6'd32 |-> !sec_nmi)
      else $error("high line reached secondary core");
   cover property (main_late_q);
   cover property (main_take && main_irq_req);
   cover property (sec_nmi);
endmodule // vim_sva
bind vim_top vim_sva u_sva (.core_clk(core_clk), .rst_n(rst_n),
   .main_exec_prio(main_exec_prio), .sec_exec_prio(sec_exec_prio),
   .main_irq_req(main_irq_req), .sec_irq_req(sec_irq_req),
   .main_set_enable_low(main_set_enable_low), .main_clr_enable_low(main_clr_enable_low),
   .main_enable_low_q(main_enable_low_q), .main_take(main_take),
   .main_vbase_we(main_vbase_we), .main_vbase_wdata(main_vbase_wdata),
   .main_vec_q(main_vec_q), .main_fetch_addr_q(main_fetch_addr_q),
   .main_late_q(main_late_q), .nmi_route_sel(nmi_route_sel), .sec_nmi(sec_nmi));
`default_nettype wire

// *** sim/vectored_interrupt_mapping_test.sv ***
// Purpose: Self-checking bench for the vectored interrupt mapping block.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes: Results are queued by the driver and popped by the monitor.
`timescale 1ns/1ps
`default_nettype none
module vectored_interrupt_mapping_test;
   logic core_clk = 1'b0, rst_n = 1'b0, vb_we = 1'b0, nmi_en = 1'b0, hit_n = 1'b0;
   logic [46:0] src = '0;
   logic [31:0] set_lo = '0, clr_lo = '0, vb_d = '0, vb = '0, rnd = 32'hcf21c540;
   logic [8:0] set_hi = '0, clr_hi = '0, en_hi;
   logic [131:0] mprio = '0;
   logic [95:0] sprio = '0;
   logic [5:0] nmi_sel = '0, mvec, svec;
   logic [2:0] mexec = '0;
   logic [1:0] sexec = '0, lag = '0;
   logic mtake, mbusy, stake, sbusy, mreq, sreq, mlate, mnmi, snmi, slate;
   logic [31:0] maddr, en_lo, saddr, sen;
   logic [40:0] expq[$];
   int fails = 0, samples_checked = 0, b;
   always #12.5 core_clk = ~core_clk;
   vim_top u_dut (.core_clk(core_clk), .rst_n(rst_n), .watchdog_warning_flag(src[0]),
      .brownout_detector(src[1]), .dma_flags(src[4:2]), .gpio_group_zero_irq(src[5]),
      .pin_irq_zero(src[9:6]), .micro_tick_timer(src[10]), .multi_rate_channel_flag(src[14:11]),
      .general_counter_timer(src[24:15]), .state_config_timer(src[25]), .serial_irq(src[34:26]),
      .converter_sequence_a_done(src[35]), .converter_sequence_b_done(src[36]),
      .converter_threshold_irq(src[37]), .clock_alarm_wake(src[39:38]), .mailbox_irq(src[40]),
      .gpio_group_one_irq(src[41]), .pin_irq_high(src[45:42]), .repetitive_compare_flag(src[46]),
      .main_set_enable_low(set_lo), .main_set_enable_high(set_hi), .main_clr_enable_low(clr_lo),
      .main_clr_enable_high(clr_hi), .main_prio_words(mprio), .main_vbase_we(vb_we),
      .main_vbase_wdata(vb_d), .sec_set_enable(set_lo), .sec_clr_enable(clr_lo),
      .sec_prio_words(sprio), .sec_vbase_we(vb_we), .sec_vbase_wdata(vb_d),
      .nmi_route_en(nmi_en), .nmi_route_sel(nmi_sel), .main_exec_prio(mexec),
      .main_entry_busy(mbusy), .main_take(mtake), .sec_exec_prio(sexec), .sec_entry_busy(sbusy),
      .sec_take(stake), .main_irq_req(mreq), .main_vec_q(mvec), .main_fetch_addr_q(maddr),
      .main_late_q(mlate), .main_enable_low_q(en_lo), .main_enable_high_q(en_hi),
      .main_nmi(mnmi), .sec_irq_req(sreq), .sec_vec_q(svec), .sec_fetch_addr_q(saddr),
      .sec_late_q(slate), .sec_enable_q(sen), .sec_nmi(snmi));
   vim_core_model u_main_core (.core_clk(core_clk), .rst_n(rst_n), .irq_req(mreq), .lag(lag),
      .take(mtake), .entry_busy(mbusy));
   vim_core_model u_sec_core (.core_clk(core_clk), .rst_n(rst_n), .irq_req(sreq), .lag(lag),
      .take(stake), .entry_busy(sbusy));
   ////////////////////////////////////////////////////////////////
   // Helpers: drive timing, comparison, expected line of each source bit
   task automatic tick(int n = 1);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic chk(string nm, logic [40:0] seen, logic [40:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tally_and_finish;
      $display("fails=%0d samples_checked=%0d", fails, samples_checked);
      if (fails == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // Bounded wait for queued results and for the core to finish entry
   task automatic drain(bit busy_too);
      int i;
      for (i = 0; i < 40 && (expq.size() > 0 || (busy_too && mbusy !== 1'b0)); i++) tick();
      if (i == 40) begin
         fails++;
         tally_and_finish();
      end
   endtask
   function automatic logic [31:0] lfsr(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic int ln(int k);
      if (k < 2) return k;
      if (k < 5) return 3;
      if (k == 5) return 4;
      if (k < 10) return k - 1;
      if (k == 10) return 9;
      if (k < 15) return 10;
      if (k < 25) return 11 + (k - 15) / 2;
      if (k == 25) return 16;
      if (k < 38 || (k > 40 && k < 46)) return k - 9;
      if (k < 40) return 29;
      return (k == 40) ? 31 : 40;
   endfunction
   function automatic logic [40:0] expv(logic late, int line);
      return {2'b00, late, 6'(line), vb + 32'((line + 16) * 4)};
   endfunction
   // Queue a result, raise sources, wait for it, then drop them
   task automatic serve(logic [46:0] s, int line);
      expq.push_back(expv(1'b0, line));
      src = s;
      drain(1'b1);
      src = '0;
      tick();
   endtask
   ////////////////////////////////////////////////////////////////
   // Monitor: the oldest note is compared when a take or late swap lands
   always @(negedge core_clk) hit_n = mtake & mreq;
   always @(posedge core_clk) begin
      #2;
      if (rst_n && (hit_n === 1'b1 || mlate === 1'b1)) begin
         chk("pending_note", 41'(expq.size() > 0), 41'd1);
         if (expq.size() > 0) chk("vector", {2'b00, mlate, mvec, maddr}, expq.pop_front());
      end
   end
   initial begin
      repeat (6) @(posedge core_clk);
      #1 rst_n = 1'b1;
      chk("reset_out", {2'b00, mlate, mvec, maddr}, {3'b000, 6'h3f, 32'h0});
      chk("reset_en", {en_hi, en_lo}, 41'h0);
      chk("reset_sec", {2'b00, slate, svec, saddr}, {3'b000, 6'h3f, 32'h0});
      chk("reset_sec_en", 41'(sen), 41'h0);
      rnd = lfsr(rnd);
      set_lo = rnd;
      set_hi = rnd[8:0];
      tick();
      chk("en_set", {en_hi, en_lo}, {rnd[8:0], rnd});
      chk("sec_en_set", 41'(sen), 41'(rnd));
      {set_lo, set_hi, clr_lo, clr_hi} = {41'h0, {41{1'b1}}};
      tick();
      chk("en_clear", {en_hi, en_lo}, 41'h0);
      chk("sec_en_clear", 41'(sen), 41'h0);
      rnd = lfsr(rnd);
      {set_lo, set_hi} = {rnd, rnd[8:0]};
      tick();
      chk("en_set_wins", {en_hi, en_lo}, {rnd[8:0], rnd});
      chk("sec_en_wins", 41'(sen), 41'(rnd));
      {set_lo, set_hi, clr_lo, clr_hi} = {{41{1'b1}}, 41'h0};
      rnd = lfsr(rnd);
      {vb_we, vb_d, vb} = {1'b1, rnd, rnd[31:7], 7'h00};
      tick();
      {set_lo, set_hi, vb_we, nmi_en, mexec, sexec} = {41'h0, 1'b0, 1'b1, 3'h7, 2'h3};
      tick();
      chk("idle_reserved", 41'({mreq, sreq, mnmi}), 41'h0);
      // Each line routed to the NMI with all sources high; level zero masks all
      {mexec, sexec, src} = {3'h0, 2'h0, {47{1'b1}}};
      for (b = 0; b < 41; b++) begin
         tick();
         nmi_sel = 6'(b);
         #1 chk("nmi_line", 41'(mnmi), 41'(b != 2 && b != 30 && (b < 37 || b > 39)));
         chk("mask_zero", 41'({mreq, sreq}), 41'h0);
      end
      nmi_en = 1'b0;
      #1 chk("nmi_off", 41'(mnmi), 41'h0);
      {mexec, sexec, nmi_en} = {3'h7, 2'h3, 1'b1};
      for (b = 0; b < 47; b++) begin
         rnd = lfsr(rnd);
         lag = rnd[1:0];
         nmi_sel = 6'(ln(b));
         src = 47'h1 << b;
         #1;
         chk("nmi_sec_reach", 41'({mnmi, snmi, sreq}), 41'({1'b1, ln(b) < 32, ln(b) < 32}));
         serve(47'h1 << b, ln(b));
         chk("sec_vector", {2'b00, slate, svec, saddr}, expv(1'b0, ln(b) < 32 ? ln(b) : 31));
      end
      {lag, mprio[9 +: 3], sprio[9 +: 3], mexec, sexec} = {2'd0, 3'h3, 3'h4, 3'h3, 2'h2};
      src = 47'h4;
      #1;
      chk("prio_masked", 41'({mreq, sreq}), 41'h0);
      {mexec, sexec} = {3'h4, 2'h3};
      #1;
      chk("prio_passed", 41'({mreq, sreq}), 41'h3);
      serve(47'h4, 3);
      {mexec, mprio[9 +: 3], mprio[60 +: 3]} = {3'h7, 3'h5, 3'h2};
      serve(47'h2000_0004, 20);
      mprio[60 +: 3] = 3'h5;
      serve(47'h2000_0004, 3);
      mprio[60 +: 3] = 3'h2;
      expq.push_back(expv(1'b0, 3));
      src = 47'h4;
      drain(1'b0);
      expq.push_back(expv(1'b1, 20));
      src = 47'h2000_0004;
      drain(1'b1);
      chk("late_queue", 41'(expq.size()), 41'h0);
      chk("late_hold", {2'b00, mlate, mvec, maddr}, expv(1'b0, 20));
      chk("sec_late", {2'b00, slate, svec, saddr}, expv(1'b0, 20));
      src = '0;
      tick();
      tally_and_finish();
   end
endmodule // vectored_interrupt_mapping_test
`default_nettype wire
